/* File: dv/drp_monitor.sv */
// assertion checker for the display ram pointer block
`timescale 1ns/1ps
`default_nettype none
module drp_monitor (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // register bus
  input wire logic [3:0] avs_address_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic avs_waitrequest_o,
  // ram port
  input wire logic ram_req_o,
  input wire logic ram_we_o,
  input wire logic [2:0] ram_page_o,
  input wire logic [6:0] ram_line_o,
  input wire logic [7:0] ram_wdata_o,
  input wire logic ram_ready_i,
  // display settings
  input wire logic [5:0] start_line_o,
  input wire logic [7:0] contrast_o,
  input wire logic seg_remap_o,
  input wire logic entire_on_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // command byte accepted at this edge
  wire cmd_tk = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0
    && avs_byteenable_i[0];
  // the byte itself
  wire [7:0] wd = avs_writedata_i[7:0];
  // ram transfer at this edge
  wire ram_tk = ram_req_o && ram_ready_i;
  ////////////////////
  // expected settings kept in helper flops, so no property needs local variables
  logic con_arm_ff; // the next command byte is a contrast value
  logic [5:0] exp_line_ff; // last start line commanded
  logic [7:0] exp_con_ff; // last contrast value commanded
  // follow the command stream; only the contrast argument byte is kept from being read as a start line
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      con_arm_ff <= 1'b0;
      exp_line_ff <= 6'h00;
      exp_con_ff <= 8'h00;
    end else if (cmd_tk) begin
      con_arm_ff <= !con_arm_ff && wd == 8'h81;
      if (con_arm_ff) begin
        exp_con_ff <= wd;
      end else if (wd[7:6] == 2'h1) begin
        exp_line_ff <= wd[5:0];
      end
    end
  end
  a_start_line: assert property (cmd_tk && !con_arm_ff && wd[7:6] == 2'h1
    |-> ##[1:8] start_line_o == exp_line_ff)
    else $error("start line not taken from command");
  a_contrast_byte: assert property (cmd_tk && con_arm_ff
    |-> ##[1:8] contrast_o == exp_con_ff)
    else $error("contrast byte not stored");
  a_allon_set: assert property (cmd_tk && wd == 8'ha5 |-> ##[1:8] entire_on_o)
    else $error("all-on not forced");
  a_allon_clr: assert property (cmd_tk && wd == 8'ha4 |-> ##[1:8] !entire_on_o)
    else $error("all-on not released");
  a_remap_set: assert property (cmd_tk && wd == 8'ha1 |-> ##[1:8] seg_remap_o)
    else $error("remap not set");
  a_remap_clr: assert property (cmd_tk && wd == 8'ha0 |-> ##[1:8] !seg_remap_o)
    else $error("remap not cleared");
  // a waiting request must not move, or a remap could bend it mid-flight
  a_ram_hold: assert property (ram_req_o && !ram_ready_i |=> ram_req_o
    && $stable({ram_we_o, ram_page_o, ram_line_o, ram_wdata_o}))
    else $error("ram request changed while waiting");
  a_ram_once: assert property (ram_tk |=> !ram_req_o)
    else $error("ram request repeated after transfer");
  // main traffic
  c_ram_wr: cover property (ram_tk && ram_we_o);
  c_ram_rd: cover property (ram_tk && !ram_we_o);
  c_ram_stall: cover property (ram_req_o && !ram_ready_i);
endmodule
bind drp_top drp_monitor mon (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_waitrequest_o(avs_waitrequest_o), .ram_req_o(ram_req_o), .ram_we_o(ram_we_o),
  .ram_page_o(ram_page_o), .ram_line_o(ram_line_o), .ram_wdata_o(ram_wdata_o),
  .ram_ready_i(ram_ready_i), .start_line_o(start_line_o), .contrast_o(contrast_o),
  .seg_remap_o(seg_remap_o), .entire_on_o(entire_on_o));
`default_nettype wire

/* File: dv/drp_ram_model.sv */
// behavioural display ram behind the block's ram port
`timescale 1ns/1ps
`default_nettype none
module drp_ram_model (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // request side
  input wire logic req_i,
  input wire logic we_i,
  input wire logic [2:0] page_i,
  input wire logic [6:0] line_i,
  input wire logic [7:0] wdata_i,
  output logic ready_o,
  output logic [7:0] rdata_o,
  // cycles to stall each request
  input wire logic [3:0] stall_i
);
  logic [7:0] mem [0:1023]; // page times 128 plus line
  logic [7:0] last_ff; // last read bus value
  logic [3:0] wait_ff; // cycles the request has waited
  // accept once the stall has run out
  assign ready_o = req_i && wait_ff >= stall_i;
  // off-answer the bus flips each cycle so stale data never looks valid
  assign rdata_o = (ready_o && !we_i) ? mem[{page_i, line_i}] : ~last_ff;
  // stall count, bus history and writes
  always @(posedge ref_clk_i) begin
    wait_ff <= (!resetn_i || !req_i || ready_o) ? 4'h0 : wait_ff + 4'h1;
    last_ff <= resetn_i ? rdata_o : 8'h00;
    if (ready_o && we_i) begin
      mem[{page_i, line_i}] <= wdata_i;
    end
  end
endmodule
`default_nettype wire

/* File: dv/tb_display_ram_address_pointer.sv */
// self-checking testbench for the display ram pointer block
`timescale 1ns/1ps
`default_nettype none
`include "drp_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_display_ram_address_pointer;
  logic ref_clk_i, resetn_i, avs_read_i, avs_write_i;
  logic [3:0] avs_address_i, avs_byteenable_i, stall;
  logic [31:0] avs_writedata_i, q;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o, ram_req_o, ram_we_o, ram_ready_i, seg_remap_o, entire_on_o;
  wire [2:0] ram_page_o;
  wire [6:0] ram_line_o;
  wire [7:0] ram_wdata_o, ram_rdata_i, contrast_o;
  wire [5:0] start_line_o;
  int err_count, compares, maxw;
  drp_top dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .ram_req_o(ram_req_o), .ram_we_o(ram_we_o),
    .ram_page_o(ram_page_o), .ram_line_o(ram_line_o), .ram_wdata_o(ram_wdata_o),
    .ram_ready_i(ram_ready_i), .ram_rdata_i(ram_rdata_i), .start_line_o(start_line_o),
    .contrast_o(contrast_o), .seg_remap_o(seg_remap_o), .entire_on_o(entire_on_o));
  drp_ram_model ram (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(ram_req_o),
    .we_i(ram_we_o), .page_i(ram_page_o), .line_i(ram_line_o), .wdata_i(ram_wdata_o),
    .ready_o(ram_ready_i), .rdata_o(ram_rdata_i), .stall_i(stall));
  ////////////////////
  // one avalon access, held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {24'h0, d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 300);
    q = avs_readdata_o;
    maxw = (n > maxw) ? n : maxw;
    if (n >= 300) err_count++;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  // low n bytes of s as commands, high byte first
  task cmds(input logic [23:0] s, input int n);
    for (int i = n - 1; i >= 0; i--) bus(1'b1, `DRP_OFS_CMD, s[8*i +: 8]);
  endtask
  // poll until buffer and ram port are empty
  task idle;
    int k;
    k = 0;
    do begin
      bus(1'b0, `DRP_OFS_SET, 8'h00);
      k++;
    end while (q[25:24] !== 2'b00 && k < 50);
    `CHK(q[25:24], 2'b00)
  endtask
  task t_page;
    cmds(24'hb20511, 3);
    bus(1'b1, `DRP_OFS_DATA, 8'h11);
    bus(1'b1, `DRP_OFS_DATA, 8'h22);
    idle;
    `CHK(ram.mem[2*128+21], 8'h11)
    `CHK(ram.mem[2*128+22], 8'h22)
    bus(1'b0, `DRP_OFS_PTR, 8'h00);
    `CHK({q[18:16], q[6:0]}, {3'h2, 7'h17})
    $display("test page done");
  endtask
  task t_vert;
    cmds(24'h2001, 2);
    cmds(24'h220103, 3);
    cmds(24'h210203, 3);
    for (int i = 0; i < 7; i++) bus(1'b1, `DRP_OFS_DATA, 8'h30 + i[7:0]);
    idle;
    for (int i = 1; i < 6; i++) begin
      `CHK(ram.mem[(1 + i % 3)*128 + 2 + i / 3], 8'h30 + i[7:0])
    end
    `CHK(ram.mem[1*128+2], 8'h36)
    bus(1'b0, `DRP_OFS_PTR, 8'h00);
    `CHK({q[18:16], q[14:8]}, {3'h2, 7'h02})
    $display("test vertical done");
  endtask
  // ram stalls so the buffer fills and writes must wait
  task t_horz;
    cmds(24'h2009, 2);
    cmds(24'h210405, 3);
    cmds(24'h220607, 3);
    stall <= 4'h8;
    maxw = 0;
    for (int i = 0; i < 5; i++) bus(1'b1, `DRP_OFS_DATA, 8'h40 + i[7:0]);
    idle;
    stall <= 4'h0;
    `CHK(maxw > 2, 1'b1)
    for (int i = 1; i < 4; i++) begin
      `CHK(ram.mem[(6 + i / 2)*128 + 4 + i % 2], 8'h40 + i[7:0])
    end
    `CHK(ram.mem[6*128+4], 8'h44)
    $display("test horizontal done");
  endtask
  // bad mode field, read-only and unmapped places
  task t_mode;
    cmds(24'h2005, 2);
    bus(1'b1, `DRP_OFS_PTR, 8'hff);
    bus(1'b0, `DRP_OFS_PTR, 8'h00);
    `CHK(q[27:24], `DRP_MODE_HORZ)
    `CHK({q[18:16], q[6:0]}, {3'h6, 7'h05})
    bus(1'b0, 4'h6, 8'h00);
    `CHK(q, 32'h0)
    $display("test mode done");
  endtask
  // first read is a dummy, the second returns the byte
  task t_read;
    cmds(24'h2002, 2);
    cmds(24'hb20511, 3);
    bus(1'b0, `DRP_OFS_DATA, 8'h00);
    `CHK(q[7:0], 8'h00)
    idle;
    bus(1'b0, `DRP_OFS_DATA, 8'h00);
    `CHK(q[7:0], 8'h11)
    idle;
    bus(1'b0, `DRP_OFS_PTR, 8'h00);
    `CHK(q[6:0], 7'h17)
    $display("test read done");
  endtask
  task t_set;
    `CHK(contrast_o, `DRP_RST_CONTRAST)
    cmds(24'h7f81c3, 3);
    cmds(24'h8101a1, 3);
    cmds(24'hb00010, 3);
    bus(1'b1, `DRP_OFS_DATA, 8'h5a);
    cmds(24'h00a0b0, 2);
    cmds(24'h000010, 2);
    bus(1'b1, `DRP_OFS_DATA, 8'h6b);
    idle;
    `CHK({start_line_o, contrast_o}, {6'h3f, 8'h01})
    // an ignored two-byte command must swallow a page-like argument
    cmds(24'h00d3b5, 2);
    bus(1'b0, `DRP_OFS_PTR, 8'h00);
    `CHK(q[18:16], 3'h0)
    `CHK(ram.mem[127], 8'h5a)
    `CHK({ram.mem[0], seg_remap_o}, {8'h6b, 1'b0})
    avs_byteenable_i <= 4'h0;
    cmds(24'h0000a5, 1);
    avs_byteenable_i <= 4'hf;
    idle;
    `CHK(entire_on_o, 1'b0)
    cmds(24'h0000a5, 1);
    idle;
    `CHK(entire_on_o, 1'b1)
    cmds(24'h0000a4, 1);
    idle;
    `CHK(entire_on_o, 1'b0)
    $display("test settings done");
  endtask
  // counts, verdict and end of run
  task print_verdict;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  ////////////////////
  // 125 mhz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  // reset, then the tests in turn
  initial begin
    resetn_i = 1'b0;
    {avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, stall} = '0;
    avs_byteenable_i = 4'hf;
    repeat (16) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    t_page;
    t_vert;
    t_horz;
    t_mode;
    t_read;
    t_set;
    print_verdict;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #400000;
    err_count++;
    print_verdict;
  end
endmodule
`default_nettype wire

/* File: src/drp_buf.v */
// two-entry buffer between the register bus and the command interpreter
`timescale 1ns/1ps
`default_nettype none

module drp_buf #(
  parameter WIDTH = 10,
  parameter DEPTH = 2,
  parameter AW = 1
) (
  // clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // filling side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  // draining side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);

  reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // storage words
  reg [AW-1:0] wr_ptr_ff; // next slot to fill
  reg [AW-1:0] rd_ptr_ff; // oldest slot
  reg [AW:0] count_ff; // words held
  wire push; // word taken in
  wire pop; // word handed on

  assign in_ready_o = (count_ff != DEPTH[AW:0]);
  assign out_valid_o = (count_ff != {(AW+1){1'b0}});
  assign out_data_o = mem_ff[rd_ptr_ff];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // pointer and count update; a full buffer stalls the source
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      wr_ptr_ff <= {AW{1'b0}};
      rd_ptr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
      end
      if (pop) begin
        rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
      end
      if (push && !pop) begin
        count_ff <= count_ff + 1'b1;
      end else if (pop && !push) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // storage write, no reset needed for data words
  always @(posedge ref_clk_i) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data_i;
    end
  end

endmodule

`default_nettype wire

/* File: src/drp_map.vh */
// constants for the display ram address pointer block
`ifndef DRP_MAP_VH
`define DRP_MAP_VH

// avalon byte offsets
`define DRP_OFS_CMD 4'h0
`define DRP_OFS_DATA 4'h4
`define DRP_OFS_PTR 4'h8
`define DRP_OFS_SET 4'hc

// addressing mode field encodings
`define DRP_MODE_PAGE 4'h2
`define DRP_MODE_VERT 4'h1
`define DRP_MODE_HORZ 4'h9

// buffer entry kinds
`define DRP_OP_CMD 2'h0
`define DRP_OP_WR 2'h1
`define DRP_OP_RD 2'h2

// command bytes
`define DRP_CMD_MODE 8'h20
`define DRP_CMD_LINE 8'h21
`define DRP_CMD_PAGEWIN 8'h22
`define DRP_CMD_CONTRAST 8'h81
`define DRP_CMD_REMAP0 8'ha0
`define DRP_CMD_REMAP1 8'ha1
`define DRP_CMD_RAMSHOW 8'ha4
`define DRP_CMD_ALLON 8'ha5

// reset values
`define DRP_RST_CONTRAST 8'h7f
`define DRP_RST_LINE_END 7'h7f
`define DRP_RST_PAGE_END 3'h7

// status field positions in the pointer register
`define DRP_PTR_COL_LSB 0
`define DRP_PTR_ROW_LSB 8
`define DRP_PTR_PAGE_LSB 16
`define DRP_PTR_MODE_LSB 24

`endif

/* File: src/drp_top.v */
// display ram address pointer, command interpreter and avalon slave
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "drp_map.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - page mode: column plus one, page held
// - page mode start: b0h page, nibble commands
// - column pointer is high nibble over low
// - vertical wrap: page steps, wraps, row steps
// - vertical wrap: both at end reload both
// - horizontal wrap: column steps on writes, then page
// - horizontal wrap: both at end reload both
// - 21h stores line window, loads line pointer in wrap modes
// - 22h stores page window, loads page pointer
// - wrap-mode steps stay in the window; b0h and nibble commands can set it outside
// - 40h-7fh set display start line
// - 81h plus byte sets contrast
// - a0h/a1h remap applies to later writes except in vertical mode
// - a5h forces all pixels, a4h restores
// - 20h plus field picks addressing mode
module drp_top (
  // clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // avalon-mm slave
  input wire [3:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  // display ram access port
  output reg ram_req_o,
  output reg ram_we_o,
  output reg [2:0] ram_page_o,
  output reg [6:0] ram_line_o,
  output reg [7:0] ram_wdata_o,
  input wire ram_ready_i,
  input wire [7:0] ram_rdata_i,
  // display settings
  output reg [5:0] start_line_o,
  output reg [7:0] contrast_o,
  output reg seg_remap_o,
  output reg entire_on_o
);

  // interpreter states, one-hot
  localparam [7:0] ST_IDLE = 8'h01;
  localparam [7:0] ST_MODE = 8'h02;
  localparam [7:0] ST_LS = 8'h04;
  localparam [7:0] ST_LE = 8'h08;
  localparam [7:0] ST_PS = 8'h10;
  localparam [7:0] ST_PE = 8'h20;
  localparam [7:0] ST_CON = 8'h40;
  localparam [7:0] ST_SKIP = 8'h80;

  ////////////////////////////////////////////////////////////////////////////
  // bus slave and buffer
  wire bus_req; // any request present
  wire bus_take; // request completes at this edge
  wire is_cmd; // command offset
  wire is_data; // data offset
  wire push_valid; // entry offered to buffer
  wire [9:0] push_data; // {op, byte}
  wire buf_in_ready; // buffer has room
  wire buf_out_valid; // entry waiting
  wire [9:0] buf_out_data; // oldest entry
  wire buf_pop; // interpreter takes entry
  reg [7:0] rd_latch_ff; // last byte read from ram

  assign bus_req = avs_read_i | avs_write_i;
  assign bus_take = bus_req & ~avs_waitrequest_o;
  assign is_cmd = (avs_address_i == `DRP_OFS_CMD);
  assign is_data = (avs_address_i == `DRP_OFS_DATA);
  // only command and data accesses enter the buffer
  assign push_valid = bus_take & ((avs_write_i & avs_byteenable_i[0] & (is_cmd | is_data))
                      | (avs_read_i & is_data));
  assign push_data = {avs_read_i ? `DRP_OP_RD : (is_cmd ? `DRP_OP_CMD : `DRP_OP_WR),
                      avs_writedata_i[7:0]};

  drp_buf #(
    .WIDTH(10),
    .DEPTH(2),
    .AW(1)
  ) u_buf (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .in_valid_i(push_valid),
    .in_ready_o(buf_in_ready),
    .in_data_i(push_data),
    .out_valid_o(buf_out_valid),
    .out_ready_i(buf_pop),
    .out_data_o(buf_out_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pointer state
  reg [7:0] state_ff; // interpreter state
  reg [3:0] mode_ff; // addressing mode field
  reg [6:0] col_ff; // column pointer
  reg [6:0] row_ff; // row pointer
  reg [2:0] page_ff; // page pointer
  reg [6:0] line_start_ff; // line window start
  reg [6:0] line_end_ff; // line window end
  reg [2:0] page_start_ff; // page window start
  reg [2:0] page_end_ff; // page window end

  // wrap within a window; >= keeps a stray pointer from running away
  function [6:0] step_line;
    input [6:0] cur;
    input [6:0] lo;
    input [6:0] hi;
    begin
      step_line = (cur >= hi) ? lo : cur + 7'h01;
    end
  endfunction

  // same for the 3-bit page pointer
  function [2:0] step_page;
    input [2:0] cur;
    input [2:0] lo;
    input [2:0] hi;
    begin
      step_page = (cur >= hi) ? lo : cur + 3'h1;
    end
  endfunction

  // bus answer: one wait cycle, then ack when the buffer has room
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else if (bus_req && avs_waitrequest_o) begin
      // data accesses and command writes wait for room, byte 0 enabled or not; others answer at once
      if (buf_in_ready || !(is_data || (is_cmd && avs_write_i))) begin
        avs_waitrequest_o <= 1'b0;
      end
      case (avs_address_i)
        `DRP_OFS_DATA: avs_readdata_o <= {24'h00_0000, rd_latch_ff};
        `DRP_OFS_PTR: avs_readdata_o <= {4'h0, mode_ff, 5'h00, page_ff,
                                         1'b0, row_ff, 1'b0, col_ff};
        `DRP_OFS_SET: avs_readdata_o <= {6'h00, buf_out_valid, ram_req_o,
                                         6'h00, entire_on_o, seg_remap_o,
                                         2'h0, start_line_o, contrast_o};
        default: avs_readdata_o <= 32'h0000_0000;
      endcase
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interpreter
  wire [1:0] op; // entry kind
  wire [7:0] byte_v; // entry byte
  wire horz; // horizontal wrap mode active
  wire vert; // vertical wrap mode active
  wire [6:0] map_col; // column after segment remap

  assign op = buf_out_data[9:8];
  assign byte_v = buf_out_data[7:0];
  assign horz = (mode_ff == `DRP_MODE_HORZ);
  assign vert = (mode_ff == `DRP_MODE_VERT);
  // ram busy stalls the buffer so no word is lost
  assign buf_pop = buf_out_valid & ~ram_req_o;
  // remap mirrors the column only for accesses issued from now on
  assign map_col = seg_remap_o ? (7'h7f - col_ff) : col_ff;

  // ram request handshake and read capture
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ram_req_o <= 1'b0;
      ram_we_o <= 1'b0;
      ram_page_o <= 3'h0;
      ram_line_o <= 7'h00;
      ram_wdata_o <= 8'h00;
      rd_latch_ff <= 8'h00;
    end else if (ram_req_o) begin
      if (ram_ready_i) begin
        ram_req_o <= 1'b0;
        if (!ram_we_o) begin
          rd_latch_ff <= ram_rdata_i;
        end
      end
    end else if (buf_pop && op != `DRP_OP_CMD) begin
      ram_req_o <= 1'b1;
      ram_we_o <= (op == `DRP_OP_WR);
      ram_page_o <= page_ff;
      ram_line_o <= vert ? row_ff : map_col;
      ram_wdata_o <= byte_v;
    end
  end

  // command decode and pointer movement
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      state_ff <= ST_IDLE;
      mode_ff <= `DRP_MODE_PAGE;
      col_ff <= 7'h00;
      row_ff <= 7'h00;
      page_ff <= 3'h0;
      line_start_ff <= 7'h00;
      line_end_ff <= `DRP_RST_LINE_END;
      page_start_ff <= 3'h0;
      page_end_ff <= `DRP_RST_PAGE_END;
      start_line_o <= 6'h00;
      contrast_o <= `DRP_RST_CONTRAST;
      seg_remap_o <= 1'b0;
      entire_on_o <= 1'b0;
    end else if (buf_pop && op != `DRP_OP_CMD) begin
      // data access: advance pointers
      if (vert) begin
        if (page_ff >= page_end_ff) begin
          page_ff <= page_start_ff;
          row_ff <= step_line(row_ff, line_start_ff, line_end_ff);
        end else begin
          page_ff <= page_ff + 3'h1;
        end
      end else if (horz) begin
        // only writes step the pointer in this mode
        if (op == `DRP_OP_WR) begin
          if (col_ff >= line_end_ff) begin
            col_ff <= line_start_ff;
            page_ff <= step_page(page_ff, page_start_ff, page_end_ff);
          end else begin
            col_ff <= col_ff + 7'h01;
          end
        end
      end else begin
        col_ff <= col_ff + 7'h01;
      end
    end else if (buf_pop) begin
      case (state_ff)
        ST_IDLE: begin
          if (byte_v[7:4] == 4'h0) begin
            col_ff[3:0] <= byte_v[3:0];
          end else if (byte_v[7:3] == 5'b00010) begin
            col_ff[6:4] <= byte_v[2:0];
          end else if (byte_v[7:6] == 2'b01) begin
            start_line_o <= byte_v[5:0];
          end else if (byte_v[7:3] == 5'b10110) begin
            page_ff <= byte_v[2:0];
          end else begin
            case (byte_v)
              `DRP_CMD_MODE: state_ff <= ST_MODE;
              `DRP_CMD_LINE: state_ff <= ST_LS;
              `DRP_CMD_PAGEWIN: state_ff <= ST_PS;
              `DRP_CMD_CONTRAST: state_ff <= ST_CON;
              `DRP_CMD_REMAP0: seg_remap_o <= 1'b0;
              `DRP_CMD_REMAP1: seg_remap_o <= 1'b1;
              `DRP_CMD_RAMSHOW: entire_on_o <= 1'b0;
              `DRP_CMD_ALLON: entire_on_o <= 1'b1;
              // other two-byte commands: swallow their argument
              8'h8d, 8'ha8, 8'had, 8'hd3, 8'hd5, 8'hd9, 8'hda, 8'hdb, 8'hfd: begin
                state_ff <= ST_SKIP;
              end
              default: state_ff <= ST_IDLE;
            endcase
          end
        end
        ST_MODE: begin
          // unknown field values leave the mode alone
          if (byte_v[3:0] == `DRP_MODE_PAGE || byte_v[3:0] == `DRP_MODE_VERT ||
              byte_v[3:0] == `DRP_MODE_HORZ) begin
            mode_ff <= byte_v[3:0];
          end
          state_ff <= ST_IDLE;
        end
        ST_LS: begin
          line_start_ff <= byte_v[6:0];
          if (vert) begin
            row_ff <= byte_v[6:0];
          end else if (horz) begin
            col_ff <= byte_v[6:0];
          end
          state_ff <= ST_LE;
        end
        ST_LE: begin
          line_end_ff <= byte_v[6:0];
          state_ff <= ST_IDLE;
        end
        ST_PS: begin
          page_start_ff <= byte_v[2:0];
          page_ff <= byte_v[2:0];
          state_ff <= ST_PE;
        end
        ST_PE: begin
          page_end_ff <= byte_v[2:0];
          state_ff <= ST_IDLE;
        end
        ST_CON: begin
          contrast_o <= byte_v;
          state_ff <= ST_IDLE;
        end
        ST_SKIP: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire
